// ===== hdl/pin_function_params.svh
// constants for the shared local-bus pin function block
`ifndef PIN_FUNCTION_PARAMS_SVH
`define PIN_FUNCTION_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CFG_OFFSET          8'h00
`define CFG_RESET           8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_FIRST_REQ_SEL   3
`define BIT_SECOND_REQ_EN   4
`define BIT_IO_CS_EN        5
`define BIT_SHARED_FUNC     6
`define BIT_STRAP_IND       7
`define CFG_WRITE_MASK      8'h78

// ----------------------------------------
// internal i/o decode and timing
// ----------------------------------------
`define IO_DECODE_BASE      10'h022
`define IO_DECODE_MASK      10'h3fe
`define STRAP_SETTLE_NS     40
`define CLK_PERIOD_NS       10
`define STRAP_SETTLE_CYC    ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/pin_function_pkg.sv
// types for the shared local-bus pin function block
package pin_function_pkg;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    typedef struct packed {
        logic strap_ind;
        logic shared_func;
        logic io_cs_en;
        logic second_req_en;
        logic first_req_sel;
    } cfg_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10
    } init_state_t;

endpackage

// ===== hdl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
#(
    parameter int  WIDTH     = 3,
    parameter logic RESET_VAL = 1'b1
)
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);

    // ----------------------------------------
    // per-bit chain
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            logic lvl_d;

            // first stage feeds only the second
            always_comb
            begin
                lvl_d = lvl_q;
                if (s2_q == s3_q)
                begin
                    lvl_d = s3_q;
                end
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_q  <= RESET_VAL;
                    s2_q  <= RESET_VAL;
                    s3_q  <= RESET_VAL;
                    lvl_q <= RESET_VAL;
                end
                else
                begin
                    s1_q  <= pin_in[i];
                    s2_q  <= s1_q;
                    s3_q  <= s2_q;
                    lvl_q <= lvl_d;
                end
            end

            assign level[i] = lvl_q;
        end
    endgenerate

endmodule

// ===== hdl/local_bus_pin_function_select.sv
// shared local-bus pin function select with ahb-lite config register
//
// Contract
// - second request is ignored while its enable bit is 0, taken when 1; the code takes it only while the function bit is also 1.
// - with chip-select enable 0, internal i/o decodes from a1..a9 only.
// - with chip-select enable 1, internal i/o also needs chip-select low; the code needs it only while the function bit is 1.
// - function bit loads the inverted strap at power-up, then is writable.
// - function 0 drives address bits 17..19, 1 gives request/grant/cs.
// - indicator bit 7 holds the inverted strap and ignores writes.
// - indicator reads 0 for a high strap and 1 for a low strap.
// - pin function follows the writable bit only, never the indicator.
// - first select 0 gives slow-down/flush pins, 1 gives request 1/grant 1.
`timescale 1ns/1ps
`include "pin_function_params.svh"
module local_bus_pin_function_select
(
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    input  wire logic                        power_up_strap_pin,
    input  wire logic                        pin60_in,
    output pin_function_pkg::pin_drive_t     pin60_drv,
    output pin_function_pkg::pin_drive_t     pin58_drv,
    input  wire logic                        pin57_in,
    output pin_function_pkg::pin_drive_t     pin57_drv,
    input  wire logic                        pin4_in,
    output logic                             pin12_out,
    input  wire logic [2:0]                  upper_system_address_bits,
    input  wire logic                        first_grant_from_arb,
    input  wire logic                        second_grant_from_arb,
    input  wire logic                        flush_from_core,
    input  wire logic                        io_cycle,
    input  wire logic [9:0]                  io_addr,
    output logic                             first_request_active,
    output logic                             second_request_active,
    output logic                             slow_down_active,
    output logic                             internal_io_select
);
    import pin_function_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_lvl;

    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (1'b1)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({power_up_strap_pin, pin4_in, pin57_in, pin60_in}),
        .level   (pins_lvl)
    );

    logic req2_lvl;
    logic cs_lvl;
    logic pin4_lvl;
    logic strap_lvl;
    assign req2_lvl  = pins_lvl[0];
    assign cs_lvl    = pins_lvl[1];
    assign pin4_lvl  = pins_lvl[2];
    assign strap_lvl = pins_lvl[3];

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic cfg_hit(input logic [31:0] a);
        cfg_hit = (a[31:2] == 30'(`CFG_OFFSET >> 2));
    endfunction

    function automatic logic io_hit(input logic [9:0] a);
        io_hit = ((a & `IO_DECODE_MASK) == `IO_DECODE_BASE);
    endfunction

    function automatic logic [7:0] cfg_pack(input cfg_t c);
        cfg_pack = 8'h00;
        cfg_pack[`BIT_STRAP_IND]     = c.strap_ind;
        cfg_pack[`BIT_SHARED_FUNC]   = c.shared_func;
        cfg_pack[`BIT_IO_CS_EN]      = c.io_cs_en;
        cfg_pack[`BIT_SECOND_REQ_EN] = c.second_req_en;
        cfg_pack[`BIT_FIRST_REQ_SEL] = c.first_req_sel;
    endfunction

    // ----------------------------------------
    // strap capture and bus slave
    // ----------------------------------------
    // bus stalls until the strap settles, so no write races the capture
    init_state_t state_q;
    init_state_t state_d;
    logic [2:0]  settle_q;
    logic [2:0]  settle_d;
    cfg_t        cfg_q;
    cfg_t        cfg_d;
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic        ready_q;
    logic        ready_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        take;

    assign take = hsel && htrans[1] && hready && ready_q;

    always_comb
    begin
        state_d   = state_q;
        settle_d  = settle_q;
        cfg_d     = cfg_q;
        wr_pend_d = 1'b0;
        ready_d   = ready_q;
        rdata_d   = rdata_q;
        unique case (state_q)
            ST_SETTLE:
            begin
                settle_d = settle_q + 3'd1;
                if (settle_q == 3'(`STRAP_SETTLE_CYC))
                begin
                    cfg_d.shared_func = ~strap_lvl;
                    cfg_d.strap_ind   = ~strap_lvl;
                    state_d           = ST_RUN;
                    ready_d           = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (wr_pend_q)
                begin
                    cfg_d.shared_func   = hwdata[`BIT_SHARED_FUNC];
                    cfg_d.io_cs_en      = hwdata[`BIT_IO_CS_EN];
                    cfg_d.second_req_en = hwdata[`BIT_SECOND_REQ_EN];
                    cfg_d.first_req_sel = hwdata[`BIT_FIRST_REQ_SEL];
                end
                if (take)
                begin
                    wr_pend_d = hwrite && cfg_hit(haddr);
                    rdata_d   = 32'h0000_0000;
                    if (!hwrite && cfg_hit(haddr))
                    begin
                        // forward a write landing this cycle
                        rdata_d[7:0] = cfg_pack(cfg_d);
                    end
                end
            end
            default:
            begin
                state_d = ST_SETTLE;
                ready_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q   <= ST_SETTLE;
            settle_q  <= 3'd0;
            cfg_q     <= cfg_t'(5'h00);
            wr_pend_q <= 1'b0;
            ready_q   <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            state_q   <= state_d;
            settle_q  <= settle_d;
            cfg_q     <= cfg_d;
            wr_pend_q <= wr_pend_d;
            ready_q   <= ready_d;
            rdata_q   <= rdata_d;
        end
    end

    assign hreadyout = ready_q;
    assign hrdata    = rdata_q;
    assign hresp     = 1'b0;

    // ----------------------------------------
    // pin muxing and request qualification
    // ----------------------------------------
    pin_drive_t p60_d;
    pin_drive_t p58_d;
    pin_drive_t p57_d;
    pin_drive_t p60_q;
    pin_drive_t p58_q;
    pin_drive_t p57_q;
    logic       p12_d;
    logic       p12_q;
    logic       req1_d;
    logic       req1_q;
    logic       req2_d;
    logic       req2_q;
    logic       slow_d;
    logic       slow_q;
    logic       io_d;
    logic       io_q;
    logic       req2_ok;
    logic       cs_ok;

    always_comb
    begin
        // enable only meaningful in request mode
        // chip-select only meaningful in cs mode
        req2_ok = cfg_q.shared_func && cfg_q.second_req_en;
        cs_ok   = cfg_q.shared_func && cfg_q.io_cs_en;
        p60_d.oe = !cfg_q.shared_func;
        p60_d.o  = upper_system_address_bits[0];
        p57_d.oe = !cfg_q.shared_func;
        p57_d.o  = upper_system_address_bits[2];
        p58_d.oe = 1'b1;
        p58_d.o  = cfg_q.shared_func ? !(req2_ok && second_grant_from_arb)
                                     : upper_system_address_bits[1];
        // request 2 gated by its enable
        req2_d   = req2_ok && !req2_lvl;
        // pins 4 and 12 function choice
        req1_d   = cfg_q.first_req_sel && !pin4_lvl;
        slow_d   = !cfg_q.first_req_sel && !pin4_lvl;
        p12_d    = cfg_q.first_req_sel ? !first_grant_from_arb
                                       : !flush_from_core;
        io_d     = io_cycle && io_hit(io_addr) && (!cs_ok || !cs_lvl);
    end

    // pins 60, 58 and 57 idle undriven and pin 12 idles high until the strap picks a mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            p60_q  <= '{o: 1'b0, oe: 1'b0};
            p58_q  <= '{o: 1'b1, oe: 1'b0};
            p57_q  <= '{o: 1'b0, oe: 1'b0};
            p12_q  <= 1'b1;
            req1_q <= 1'b0;
            req2_q <= 1'b0;
            slow_q <= 1'b0;
            io_q   <= 1'b0;
        end
        else if (ready_q)
        begin
            p60_q  <= p60_d;
            p58_q  <= p58_d;
            p57_q  <= p57_d;
            p12_q  <= p12_d;
            req1_q <= req1_d;
            req2_q <= req2_d;
            slow_q <= slow_d;
            io_q   <= io_d;
        end
    end

    assign pin60_drv             = p60_q;
    assign pin58_drv             = p58_q;
    assign pin57_drv             = p57_q;
    assign pin12_out             = p12_q;
    assign first_request_active  = req1_q;
    assign second_request_active = req2_q;
    assign slow_down_active      = slow_q;
    assign internal_io_select    = io_q;

endmodule

// ===== dv/pin_function_checks_assertions.sv
// port-level checks for the shared pin function block
`timescale 1ns/1ps
module pin_function_checks
import pin_function_pkg::*;
(
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         hsel,
    input wire logic [31:0]                  haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic                         hready,
    input wire logic                         hreadyout,
    input wire logic                         hresp,
    input wire logic [31:0]                  hrdata,
    input wire pin_function_pkg::pin_drive_t pin60_drv,
    input wire pin_function_pkg::pin_drive_t pin58_drv,
    input wire pin_function_pkg::pin_drive_t pin57_drv,
    input wire logic [2:0]                   upper_system_address_bits,
    input wire logic                         second_grant_from_arb,
    input wire logic                         io_cycle,
    input wire logic [9:0]                   io_addr,
    input wire logic                         first_request_active,
    input wire logic                         second_request_active,
    input wire logic                         slow_down_active,
    input wire logic                         internal_io_select
);
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
// ----------------------------------------
// bus side
// ----------------------------------------
sequence rd_unmapped_s;
    hsel && htrans[1] && hready && hreadyout && !hwrite
    && haddr[31:2] != 30'h0;
endsequence
unmapped_read_a: assert property (rd_unmapped_s |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
ready_held_a: assert property (hreadyout |=> hreadyout)
    else $error("ready dropped in run");
okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
// ----------------------------------------
// pin side
// ----------------------------------------
addr_follow_a: assert property (
    pin60_drv.oe && $past(pin60_drv.oe) |-> {pin57_drv.o, pin60_drv.o}
    == {$past(upper_system_address_bits[2]),
        $past(upper_system_address_bits[0])})
    else $error("address pins do not follow");
oe_pair_a: assert property (pin60_drv.oe == pin57_drv.oe)
    else $error("shared pin enables differ");
grant_gate_a: assert property (
    !pin60_drv.oe && !$past(pin60_drv.oe) && pin58_drv.oe && !pin58_drv.o
    |-> $past(second_grant_from_arb))
    else $error("grant without arbiter grant");
req_mode_a: assert property (
    pin60_drv.oe && $past(pin60_drv.oe, 2) |-> !second_request_active)
    else $error("request active in address mode");
io_decode_a: assert property (
    internal_io_select |-> $past(io_cycle) && $past(io_addr[9:1]) == 9'h011)
    else $error("io select outside decode");
first_excl_a: assert property (
    !(first_request_active && slow_down_active))
    else $error("both pin4 functions active");
endmodule
bind local_bus_pin_function_select pin_function_checks u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .pin60_drv, .pin58_drv, .pin57_drv,
    .upper_system_address_bits, .second_grant_from_arb, .io_cycle, .io_addr,
    .first_request_active, .second_request_active, .slow_down_active,
    .internal_io_select);

// ===== dv/local_master_model.sv
// far-side masters and chip-select driver on the shared pins
`timescale 1ns/1ps
module local_master_model
import pin_function_pkg::*;
(
    input  wire logic                         req2_n,
    input  wire logic                         cs_n,
    input  wire logic                         req1_n,
    input  wire pin_function_pkg::pin_drive_t pin60_drv,
    input  wire pin_function_pkg::pin_drive_t pin57_drv,
    output logic                              pin60_in,
    output logic                              pin57_in,
    output logic                              pin4_in
);
// ----------------------------------------
// wire resolution
// ----------------------------------------
// the chip owns the wire while it drives an address bit
assign pin60_in = pin60_drv.oe ? pin60_drv.o : req2_n;
assign pin57_in = pin57_drv.oe ? pin57_drv.o : cs_n;
assign pin4_in  = req1_n;
endmodule

// ===== dv/local_bus_pin_function_select_tb_top.sv
// self-checking bench for the shared pin function block
`timescale 1ns/1ps
module local_bus_pin_function_select_tb_top;
import pin_function_pkg::*;
logic        hclk, hresetn, hsel, hwrite, strap, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata, rd;
logic [1:0]  htrans;
logic [2:0]  hsize, usa;
logic        req2_n, cs_n, pin4_n, p60_in, p57_in, p4_in, pin12_out;
logic        g1, g2, flush, io_cycle, req1_act, req2_act, slow_act, io_sel;
logic [9:0]  io_addr;
pin_drive_t  p60, p58, p57;
int          err_total, cmp_count;
local_bus_pin_function_select dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .power_up_strap_pin(strap), .pin60_in(p60_in), .pin60_drv(p60),
    .pin58_drv(p58), .pin57_in(p57_in), .pin57_drv(p57), .pin4_in(p4_in),
    .pin12_out, .upper_system_address_bits(usa), .first_grant_from_arb(g1),
    .second_grant_from_arb(g2), .flush_from_core(flush), .io_cycle,
    .io_addr, .first_request_active(req1_act),
    .second_request_active(req2_act), .slow_down_active(slow_act),
    .internal_io_select(io_sel));
local_master_model far_end (
    .req2_n, .cs_n, .req1_n(pin4_n), .pin60_drv(p60), .pin57_drv(p57),
    .pin60_in(p60_in), .pin57_in(p57_in), .pin4_in(p4_in));
initial
begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
end
// ----------------------------------------
// shared tasks
// ----------------------------------------
task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
        err_total++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
endtask
// one single-word transfer; read data lands in rd
task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
endtask
// filter fill plus one output edge
task settle;
    repeat (8) @(posedge hclk);
endtask
task complete_run;
    $display("mismatches %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_regs(input logic s);
    strap <= s;
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, {24'h0, ~s, ~s, 6'h0});
    settle;
    chk(p60.oe, s);
    bus(1'b1, 32'h0, 32'hff);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, {24'h0, ~s, 7'h78});
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, {24'h0, ~s, 7'h00});
    settle;
    chk(p60.oe, 1'b1);
    bus(1'b1, 32'h4, 32'hff);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
endtask
task t_addr;
    usa <= 3'b101;
    settle;
    chk({p57.o, p58.o, p60.o, p57.oe, p58.oe, p60.oe}, 6'h2f);
    usa <= 3'b010;
    settle;
    chk({p57.o, p58.o, p60.o}, 3'b010);
endtask
task t_req2;
    req2_n <= 1'b0;
    g2 <= 1'b1;
    bus(1'b1, 32'h0, 32'h40);
    settle;
    chk({req2_act, p58.o, p60.oe, p57.oe}, 4'h4);
    bus(1'b1, 32'h0, 32'h50);
    settle;
    chk({req2_act, p58.o}, 2'b10);
    g2 <= 1'b0;
    settle;
    chk(p58.o, 1'b1);
    bus(1'b1, 32'h0, 32'h10);
    settle;
    chk(req2_act, 1'b0);
    req2_n <= 1'b1;
endtask
task t_iocs;
    io_cycle <= 1'b1;
    io_addr <= 10'h023;
    bus(1'b1, 32'h0, 32'h40);
    settle;
    chk(io_sel, 1'b1);
    io_addr <= 10'h024;
    settle;
    chk(io_sel, 1'b0);
    io_addr <= 10'h022;
    bus(1'b1, 32'h0, 32'h60);
    settle;
    chk(io_sel, 1'b0);
    cs_n <= 1'b0;
    settle;
    chk(io_sel, 1'b1);
    io_cycle <= 1'b0;
    cs_n <= 1'b1;
endtask
task t_first;
    pin4_n <= 1'b0;
    g1 <= 1'b1;
    bus(1'b1, 32'h0, 32'h08);
    settle;
    chk({req1_act, slow_act, pin12_out}, 3'b100);
    bus(1'b1, 32'h0, 32'h00);
    settle;
    chk({req1_act, slow_act, pin12_out}, 3'b011);
    flush <= 1'b1;
    settle;
    chk(pin12_out, 1'b0);
endtask
initial
begin
    hresetn = 1'b0; strap = 1'b0; hsel = 1'b0; htrans = 2'b00;
    haddr = 32'h0; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    usa = 3'b000; g1 = 1'b0; g2 = 1'b0; flush = 1'b0; io_cycle = 1'b0;
    io_addr = 10'h000; req2_n = 1'b1; cs_n = 1'b1; pin4_n = 1'b1;
    err_total = 0;
    cmp_count = 0;
    t_regs(1'b0);
    t_addr;
    t_req2;
    t_iocs;
    t_first;
    t_regs(1'b1);
    complete_run;
end
// run needs a few hundred cycles; this is far beyond
initial
begin
    #200us;
    err_total++;
    complete_run;
end
endmodule
